//--- mrac_ctrl.sv
// Purpose: Operating mode tracking, reset services and password gated access control
// Assumes: Configuration tool commands arrive as register writes over AXI4-Lite
// Notes:   Nonvolatile storage is modelled by registers that the power-cycle reset service spares
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module mrac_ctrl
	import mrac_pkg::*;
#(
	parameter int unsigned SW_W = 8
)
(
	input  wire logic            core_clk_i,
	input  wire logic            rst_n_i,
	input  wire logic [7:0]      awaddr_i,
	input  wire logic            awvalid_i,
	output logic                 awready_o,
	input  wire logic [31:0]     wdata_i,
	input  wire logic [3:0]      wstrb_i,
	input  wire logic            wvalid_i,
	output logic                 wready_o,
	output logic [1:0]           bresp_o,
	output logic                 bvalid_o,
	input  wire logic            bready_i,
	input  wire logic [7:0]      araddr_i,
	input  wire logic            arvalid_i,
	output logic                 arready_o,
	output logic [31:0]          rdata_o,
	output logic [1:0]           rresp_o,
	output logic                 rvalid_o,
	input  wire logic            rready_i,
	input  wire logic [SW_W-1:0] switch_i,
	input  wire logic            critical_fault_i,
	input  wire logic            diag_fail_i,
	input  wire logic            safety_conn_i,
	input  wire logic            log_error_i,
	output mrac_func_t           func_en_o,
	output logic [2:0]           module_state_indicator_o,
	output logic                 restart_o
);

	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_ok;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_ok;

	mrac_mode_t           mode_r;
	logic [4:0]           diag_cnt_r;
	logic                 lock_r;
	logic                 cfg_valid_r;
	logic [31:0]          cfg_r;
	logic [MRAC_PW_W-1:0] pw_r;
	logic                 pw_set_r;
	logic [15:0]          errlog_r;
	logic [MRAC_PW_W-1:0] pw_in_r;
	logic [31:0]          arg_r;
	logic [SW_W-1:0]      sw_cfg_r;
	logic                 safe_conn_r;
	mrac_res_t            result_r;
	logic [7:0]           evt_cnt_r;
	logic                 restart_r;

	mrac_req_t            req;
	logic                 cmd_wr;
	logic                 pw_ok;
	logic                 accept;
	logic                 is_reset;
	logic                 do_pwr;
	logic                 do_all;
	logic                 do_keep;

	mrac_axil_slave u_slave
	(
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.awaddr_i   (awaddr_i),
		.awvalid_i  (awvalid_i),
		.awready_o  (awready_o),
		.wdata_i    (wdata_i),
		.wstrb_i    (wstrb_i),
		.wvalid_i   (wvalid_i),
		.wready_o   (wready_o),
		.bresp_o    (bresp_o),
		.bvalid_o   (bvalid_o),
		.bready_i   (bready_i),
		.araddr_i   (araddr_i),
		.arvalid_i  (arvalid_i),
		.arready_o  (arready_o),
		.rdata_o    (rdata_o),
		.rresp_o    (rresp_o),
		.rvalid_o   (rvalid_o),
		.rready_i   (rready_i),
		.wr_en_o    (wr_en),
		.wr_addr_o  (wr_addr),
		.wr_data_o  (wr_data),
		.wr_strb_o  (wr_strb),
		.wr_ok_i    (wr_ok),
		.rd_addr_o  (rd_addr),
		.rd_data_i  (rd_data),
		.rd_ok_i    (rd_ok)
	);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Command decode and acceptance

	assign cmd_wr   = wr_en && (wr_addr == MRAC_OFS_CMD);
	assign req      = '{cmd: mrac_cmd_t'(wr_data[3:0]),
		pw: pw_in_r,
		arg: arg_r};
	// With no password registered any supplied value passes
	assign pw_ok    = !pw_set_r || (req.pw == pw_r);
	assign is_reset = (req.cmd == MRAC_CMD_RST_PWR) || (req.cmd == MRAC_CMD_RST_ALL) ||
		(req.cmd == MRAC_CMD_RST_KEEP);

	// Messaging is dead in critical error and during self-diagnosis
	logic msg_alive;
	assign msg_alive = (mode_r != MRAC_MODE_CRIT) && (mode_r != MRAC_MODE_DIAG);

	always_comb
	begin
		accept = 1'b0;
		if (msg_alive && pw_ok)
		begin
			case (req.cmd)
				MRAC_CMD_RST_PWR:  accept = !safe_conn_r;
				MRAC_CMD_RST_ALL,
				MRAC_CMD_RST_KEEP: accept = !safe_conn_r && !lock_r;
				MRAC_CMD_LOCK:     accept = (mode_r == MRAC_MODE_IDLE) || (mode_r == MRAC_MODE_RUN);
				MRAC_CMD_UNLOCK:   accept = (mode_r == MRAC_MODE_IDLE) || (mode_r == MRAC_MODE_RUN);
				MRAC_CMD_DOWNLOAD: accept = !lock_r && (mode_r != MRAC_MODE_ABORT);
				MRAC_CMD_TO_RUN:   accept = (mode_r == MRAC_MODE_IDLE);
				MRAC_CMD_TO_IDLE:  accept = (mode_r == MRAC_MODE_RUN);
				MRAC_CMD_SET_PW:   accept = 1'b1;
				default:           accept = 1'b0;
			endcase
		end
	end

	assign do_pwr  = cmd_wr && accept && (req.cmd == MRAC_CMD_RST_PWR);
	assign do_all  = cmd_wr && accept && (req.cmd == MRAC_CMD_RST_ALL);
	assign do_keep = cmd_wr && accept && (req.cmd == MRAC_CMD_RST_KEEP);

	////////////////////////////////////////////////////////////////////////////////
	// Operating mode

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			mode_r     <= MRAC_MODE_DIAG;
			diag_cnt_r <= 5'h00;
		end
		else if (critical_fault_i || (mode_r == MRAC_MODE_CRIT))
		begin
			mode_r <= MRAC_MODE_CRIT;
		end
		else if (do_pwr || do_all || do_keep)
		begin
			// Every reset service ends in an emulated power cycle
			mode_r     <= MRAC_MODE_DIAG;
			diag_cnt_r <= 5'h00;
		end
		else
		begin
			case (mode_r)
				MRAC_MODE_DIAG:
				begin
					if (diag_fail_i)
						mode_r <= MRAC_MODE_CRIT;
					else if (diag_cnt_r == MRAC_DIAG_LAST)
						mode_r <= cfg_valid_r ? MRAC_MODE_IDLE : MRAC_MODE_CONF;
					else
						diag_cnt_r <= diag_cnt_r + 5'h01;
				end
				MRAC_MODE_CONF:
				begin
					if (cmd_wr && accept && (req.cmd == MRAC_CMD_DOWNLOAD))
						mode_r <= MRAC_MODE_IDLE;
				end
				MRAC_MODE_IDLE:
				begin
					if (cfg_valid_r && (switch_i != sw_cfg_r))
						mode_r <= MRAC_MODE_ABORT;
					else if (cmd_wr && accept && (req.cmd == MRAC_CMD_TO_RUN))
						mode_r <= MRAC_MODE_RUN;
				end
				MRAC_MODE_RUN:
				begin
					if (cfg_valid_r && (switch_i != sw_cfg_r))
						mode_r <= MRAC_MODE_ABORT;
					else if (cmd_wr && accept && (req.cmd == MRAC_CMD_TO_IDLE))
						mode_r <= MRAC_MODE_IDLE;
				end
				MRAC_MODE_ABORT: mode_r <= MRAC_MODE_ABORT;
				MRAC_MODE_CRIT:  mode_r <= MRAC_MODE_CRIT;
				default:         mode_r <= MRAC_MODE_CRIT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Nonvolatile configuration, lock and password

	// Soft resets never touch lock_r or sw_cfg_r; reset-all restores configuration and password, keep-reset the password and unmasked configuration bits
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			cfg_r       <= MRAC_CFG_DEFAULT;
			cfg_valid_r <= 1'b0;
			sw_cfg_r    <= '0;
			lock_r      <= 1'b0;
			pw_r        <= MRAC_PW_NONE;
			pw_set_r    <= 1'b0;
		end
		else if (do_all)
		begin
			cfg_r       <= MRAC_CFG_DEFAULT;
			cfg_valid_r <= 1'b0;
			pw_r        <= MRAC_PW_NONE;
			pw_set_r    <= 1'b0;
		end
		else if (do_keep)
		begin
			// Argument bits mark configuration bits to preserve
			cfg_r       <= (cfg_r & req.arg) | (MRAC_CFG_DEFAULT & ~req.arg);
			cfg_valid_r <= 1'b0;
			pw_r        <= MRAC_PW_NONE;
			pw_set_r    <= 1'b0;
		end
		else if (cmd_wr && accept)
		begin
			case (req.cmd)
				MRAC_CMD_DOWNLOAD:
				begin
					cfg_r       <= req.arg;
					cfg_valid_r <= 1'b1;
					sw_cfg_r    <= switch_i;
				end
				MRAC_CMD_LOCK:   lock_r <= 1'b1;
				MRAC_CMD_UNLOCK: lock_r <= 1'b0;
				MRAC_CMD_SET_PW:
				begin
					pw_r     <= req.arg;
					pw_set_r <= 1'b1;
				end
				default: lock_r <= lock_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Error log, safety connection latch, request holding registers

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			errlog_r <= 16'h0000;
		else if (do_all || do_keep)
			errlog_r <= 16'h0000;
		else if (log_error_i && (errlog_r != 16'hffff))
			errlog_r <= errlog_r + 16'h0001;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			safe_conn_r <= 1'b0;
		else if (do_pwr || do_all || do_keep || (mode_r != MRAC_MODE_RUN))
			safe_conn_r <= 1'b0;
		else if (safety_conn_i)
			safe_conn_r <= 1'b1;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			pw_in_r <= '0;
			arg_r   <= 32'h0000_0000;
		end
		else if (wr_en && (wr_addr == MRAC_OFS_PW))
			pw_in_r <= merge_bytes(pw_in_r, wr_data, wr_strb);
		else if (wr_en && (wr_addr == MRAC_OFS_ARG))
			arg_r <= merge_bytes(arg_r, wr_data, wr_strb);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			result_r  <= MRAC_RES_NONE;
			evt_cnt_r <= 8'h00;
			restart_r <= 1'b0;
		end
		else
		begin
			restart_r <= do_pwr || do_all || do_keep;
			if (cmd_wr)
			begin
				result_r  <= accept ? MRAC_RES_OK : MRAC_RES_ERR;
				evt_cnt_r <= evt_cnt_r + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register map; a refused command answers SLVERR

	always_comb
	begin
		wr_ok = 1'b1;
		case (wr_addr)
			MRAC_OFS_CMD: wr_ok = accept;
			MRAC_OFS_PW,
			MRAC_OFS_ARG: wr_ok = 1'b1;
			default:      wr_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (rd_addr)
			MRAC_OFS_CMD,
			MRAC_OFS_PW:     rd_data = 32'h0000_0000;
			MRAC_OFS_ARG:    rd_data = arg_r;
			MRAC_OFS_STATUS:
			begin
				rd_data[MRAC_ST_MODE_LSB +: 3] = mode_r;
				rd_data[MRAC_ST_LOCK]          = lock_r;
				rd_data[MRAC_ST_PWSET]         = pw_set_r;
				rd_data[MRAC_ST_RUN]           = (mode_r == MRAC_MODE_RUN);
				rd_data[MRAC_ST_SAFECONN]      = safe_conn_r;
				rd_data[MRAC_ST_BUSY]          = (mode_r == MRAC_MODE_DIAG);
			end
			MRAC_OFS_RESULT: rd_data = {24'h000000, evt_cnt_r[5:0], result_r};
			MRAC_OFS_CFG:    rd_data = cfg_r;
			MRAC_OFS_ERRLOG: rd_data = {16'h0000, errlog_r};
			MRAC_OFS_EVENT:  rd_data = {24'h000000, evt_cnt_r};
			default:         rd_ok   = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Function enables per mode

	always_comb
	begin
		func_en_o = '0;
		func_en_o.safe_state = 1'b1;
		case (mode_r)
			MRAC_MODE_RUN:
			begin
				func_en_o = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
			end
			MRAC_MODE_IDLE:  func_en_o = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
			MRAC_MODE_CONF,
			MRAC_MODE_ABORT: func_en_o.msg = 1'b1;
			default:         func_en_o.msg = 1'b0;
		endcase
	end

	assign module_state_indicator_o = mode_r;
	assign restart_o                = restart_r;

endmodule

//--- mrac_pkg.sv
// Purpose: Shared constants and types for the mode, reset and access control block
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   Offsets are byte addresses
package mrac_pkg;

	localparam int unsigned MRAC_PW_W = 32;

	// Register byte offsets
	localparam logic [7:0] MRAC_OFS_CMD    = 8'h00;
	localparam logic [7:0] MRAC_OFS_PW     = 8'h04;
	localparam logic [7:0] MRAC_OFS_ARG    = 8'h08;
	localparam logic [7:0] MRAC_OFS_STATUS = 8'h0c;
	localparam logic [7:0] MRAC_OFS_RESULT = 8'h10;
	localparam logic [7:0] MRAC_OFS_CFG    = 8'h14;
	localparam logic [7:0] MRAC_OFS_ERRLOG = 8'h18;
	localparam logic [7:0] MRAC_OFS_EVENT  = 8'h1c;

	// Status word field positions
	localparam int unsigned MRAC_ST_MODE_LSB = 0;
	localparam int unsigned MRAC_ST_LOCK     = 4;
	localparam int unsigned MRAC_ST_PWSET    = 5;
	localparam int unsigned MRAC_ST_RUN      = 6;
	localparam int unsigned MRAC_ST_SAFECONN = 7;
	localparam int unsigned MRAC_ST_BUSY     = 8;

	// Reset values
	localparam logic [31:0] MRAC_CFG_DEFAULT = 32'h0000_0000;
	localparam logic [MRAC_PW_W-1:0] MRAC_PW_NONE = 32'h0000_0000;

	// Self-diagnostic duration in cycles
	localparam int unsigned MRAC_DIAG_CYCLES = 16;
	localparam logic [4:0] MRAC_DIAG_LAST = 5'h0f;

	typedef enum logic [3:0]
	{
		MRAC_CMD_NONE     = 4'h0,
		MRAC_CMD_RST_PWR  = 4'h1,
		MRAC_CMD_RST_ALL  = 4'h2,
		MRAC_CMD_RST_KEEP = 4'h3,
		MRAC_CMD_LOCK     = 4'h4,
		MRAC_CMD_UNLOCK   = 4'h5,
		MRAC_CMD_DOWNLOAD = 4'h6,
		MRAC_CMD_TO_RUN   = 4'h7,
		MRAC_CMD_TO_IDLE  = 4'h8,
		MRAC_CMD_SET_PW   = 4'h9
	} mrac_cmd_t;

	typedef enum logic [2:0]
	{
		MRAC_MODE_DIAG  = 3'h0,
		MRAC_MODE_CONF  = 3'h1,
		MRAC_MODE_IDLE  = 3'h2,
		MRAC_MODE_RUN   = 3'h3,
		MRAC_MODE_ABORT = 3'h4,
		MRAC_MODE_CRIT  = 3'h5
	} mrac_mode_t;

	typedef enum logic [1:0]
	{
		MRAC_RES_NONE = 2'h0,
		MRAC_RES_OK   = 2'h1,
		MRAC_RES_ERR  = 2'h2
	} mrac_res_t;

	// Function enables per mode
	typedef struct packed
	{
		logic user_prog;
		logic safety_io;
		logic safety_refresh;
		logic std_io;
		logic msg;
		logic safe_state;
	} mrac_func_t;

	// One command as seen by the mode engine: command write plus held password and argument
	typedef struct packed
	{
		mrac_cmd_t              cmd;
		logic [MRAC_PW_W-1:0]   pw;
		logic [31:0]            arg;
	} mrac_req_t;

endpackage

//--- mrac_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the mode, reset and access control block
// Assumes: One write and one read outstanding at most
// Notes:   Unmapped addresses answer SLVERR; write address and data taken in either order
`timescale 1ns/1ns
module mrac_axil_slave
	import mrac_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	input  wire logic [7:0]  araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	output logic             wr_en_o,
	output logic [7:0]       wr_addr_o,
	output logic [31:0]      wr_data_o,
	output logic [3:0]       wr_strb_o,
	input  wire logic        wr_ok_i,
	output logic [7:0]       rd_addr_o,
	input  wire logic [31:0] rd_data_i,
	input  wire logic        rd_ok_i
);

	logic        aw_held_r;
	logic        w_held_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;

	assign awready_o = !aw_held_r && !bvalid_o;
	assign wready_o  = !w_held_r && !bvalid_o;
	assign arready_o = !rvalid_o;

	assign wr_en_o   = aw_held_r && w_held_r;
	assign wr_addr_o = aw_addr_r;
	assign wr_data_o = w_data_r;
	assign wr_strb_o = w_strb_r;
	assign rd_addr_o = araddr_i;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end
		else if (wr_en_o)
		begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
		end
		else
		begin
			if (awvalid_i && awready_o)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= awaddr_i;
			end
			if (wvalid_i && wready_o)
			begin
				w_held_r <= 1'b1;
				w_data_r <= wdata_i;
				w_strb_r <= wstrb_i;
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			bvalid_o <= 1'b0;
			bresp_o  <= 2'h0;
		end
		else if (wr_en_o)
		begin
			bvalid_o <= 1'b1;
			bresp_o  <= wr_ok_i ? 2'h0 : 2'h2;
		end
		else if (bready_i)
		begin
			bvalid_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			rvalid_o <= 1'b0;
			rdata_o  <= 32'h0000_0000;
			rresp_o  <= 2'h0;
		end
		else if (arvalid_i && arready_o)
		begin
			rvalid_o <= 1'b1;
			rdata_o  <= rd_data_i;
			rresp_o  <= rd_ok_i ? 2'h0 : 2'h2;
		end
		else if (rready_i)
		begin
			rvalid_o <= 1'b0;
		end
	end

endmodule

//--- mrac_ctrl_monitor.sv
// Purpose: Assertions on the mode outputs of the control block
// Assumes: Mode code shows on module_state_indicator_o
// Notes:   Bound to every mrac_ctrl instance
`timescale 1ns/1ns
module mrac_ctrl_monitor
	import mrac_pkg::*;
#(
	parameter int unsigned SW_W = 8
)
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       critical_fault_i,
	input  wire mrac_func_t func_en_o,
	input  wire logic [2:0] module_state_indicator_o,
	input  wire logic       restart_o
);
	logic [2:0] ms;
	mrac_func_t fe;
	assign ms = module_state_indicator_o;
	assign fe = func_en_o;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////////////////
	sequence s_diag_hold;
		(ms == MRAC_MODE_DIAG) [*8];
	endsequence
	sequence s_diag_leave;
		(ms == MRAC_MODE_DIAG) ##1 (ms != MRAC_MODE_DIAG);
	endsequence
	sequence s_pulse;
		restart_o ##1 !restart_o;
	endsequence

	a_diag_first: assert property ($rose(rst_n_i) |-> s_diag_hold) else $error("no diagnostic after reset");
	a_diag_exit: assert property (s_diag_leave |-> ms inside {MRAC_MODE_CONF, MRAC_MODE_IDLE, MRAC_MODE_CRIT})
		else $error("bad mode after diagnostic");
	a_run_funcs: assert property (ms == MRAC_MODE_RUN |-> fe == 6'b111110) else $error("run enables wrong");
	a_idle_funcs: assert property (ms == MRAC_MODE_IDLE |-> fe == 6'b000111) else $error("idle enables wrong");
	a_abort_funcs: assert property (ms == MRAC_MODE_ABORT |-> fe == 6'b000011) else $error("abort enables wrong");
	a_crit_stop: assert property (ms == MRAC_MODE_CRIT |-> fe == 6'b000001) else $error("critical enables wrong");
	a_fault_crit: assert property (critical_fault_i |-> ##[1:3] ms == MRAC_MODE_CRIT) else $error("fault ignored");
	a_crit_sticky: assert property (ms == MRAC_MODE_CRIT |=> ms == MRAC_MODE_CRIT) else $error("critical left");
	a_run_entry: assert property (ms == MRAC_MODE_RUN && $changed(ms) |-> $past(ms) == MRAC_MODE_IDLE)
		else $error("run not from idle");
	a_restart_pulse: assert property (restart_o |-> s_pulse) else $error("restart not a pulse");
	a_restart_diag: assert property (restart_o |-> ##[0:2] ms == MRAC_MODE_DIAG)
		else $error("restart skips diagnostic");
	c_abort: cover property (ms == MRAC_MODE_ABORT);
endmodule

bind mrac_ctrl mrac_ctrl_monitor #(.SW_W(SW_W)) mrac_ctrl_monitor_inst (.*);

//--- mrac_tool_model.sv
// Purpose: AXI4-Lite master standing in for the configuration tool
// Assumes: One write and one read at a time
// Notes:   Released lines other than wstrb_o show the inverse of the last value
`timescale 1ns/1ns
module mrac_tool_model
(
	input  wire logic   core_clk_i,
	output logic [7:0]  awaddr_o,
	output logic        awvalid_o,
	input  wire logic   awready_i,
	output logic [31:0] wdata_o,
	output logic [3:0]  wstrb_o,
	output logic        wvalid_o,
	input  wire logic   wready_i,
	input  wire logic   bvalid_i,
	output logic        bready_o,
	output logic [7:0]  araddr_o,
	output logic        arvalid_o,
	input  wire logic   arready_i,
	input  wire logic   rvalid_i,
	output logic        rready_o
);
	initial
	begin
		{awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Random response delay exercises a slow tool
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad;
		bit wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge core_clk_i);
		awaddr_o <= a;
		awvalid_o <= 1'b1;
		wdata_o <= d;
		wstrb_o <= 4'hf;
		wvalid_o <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge core_clk_i);
			if (!ad && awready_i)
			begin
				ad = 1'b1;
				awvalid_o <= 1'b0;
				awaddr_o <= ~a;
			end
			if (!wd && wready_i)
			begin
				wd = 1'b1;
				wvalid_o <= 1'b0;
				wdata_o <= ~d;
			end
		end
		repeat ($urandom_range(2)) @(posedge core_clk_i);
		bready_o <= 1'b1;
		do @(posedge core_clk_i); while (!bvalid_i);
		bready_o <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_i);
		araddr_o <= a;
		arvalid_o <= 1'b1;
		do @(posedge core_clk_i); while (!arready_i);
		arvalid_o <= 1'b0;
		araddr_o <= ~a;
		repeat ($urandom_range(2)) @(posedge core_clk_i);
		rready_o <= 1'b1;
		do @(posedge core_clk_i); while (!rvalid_i);
		rready_o <= 1'b0;
	endtask
endmodule

//--- tb.sv
// Purpose: Self-checking bench for the mode, reset and access control block
// Assumes: Bus results are checked against a queue of expected notes
// Notes:   Waits of 20 cycles cover the 16-cycle diagnostic
`timescale 1ns/1ns
module tb
	import mrac_pkg::*;
;
	localparam logic [1:0] OK = 2'h0;
	localparam logic [1:0] ER = 2'h2;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] awaddr_i, araddr_i;
	logic [31:0] wdata_i, rdata_o;
	logic [3:0] wstrb_i;
	logic awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
	logic arvalid_i, arready_o, rvalid_o, rready_i, restart_o;
	logic [1:0] bresp_o, rresp_o;
	logic [7:0] switch_i = 8'h00;
	logic critical_fault_i = 1'b0;
	logic diag_fail_i = 1'b0;
	logic safety_conn_i = 1'b0;
	logic log_error_i = 1'b0;
	mrac_func_t func_en_o;
	logic [2:0] module_state_indicator_o;
	logic [33:0] exp_q[$];
	int err_count = 0;
	int tests_run = 0;
	logic [31:0] cfg, pw, mask;

	always #50 core_clk_i = ~core_clk_i;

	mrac_ctrl #(.SW_W(8)) mrac_ctrl_inst (.*);

	mrac_tool_model mrac_tool_model_inst (
		.core_clk_i(core_clk_i), .awaddr_o(awaddr_i), .awvalid_o(awvalid_i), .awready_i(awready_o),
		.wdata_o(wdata_i), .wstrb_o(wstrb_i), .wvalid_o(wvalid_i), .wready_i(wready_o),
		.bvalid_i(bvalid_o), .bready_o(bready_i), .araddr_o(araddr_i), .arvalid_o(arvalid_i),
		.arready_i(arready_o), .rvalid_i(rvalid_o), .rready_o(rready_i)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("errors %0d of %0d checks", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// An empty queue compares against unknown, so a stray response fails
	task automatic check(input logic [33:0] got);
		logic [33:0] e;
		tests_run++;
		e = 'x;
		if (exp_q.size() > 0)
			e = exp_q.pop_front();
		if (got !== e)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, e);
		end
	endtask

	always @(posedge core_clk_i)
	begin
		if (bvalid_o === 1'b1 && bready_i === 1'b1)
			check({bresp_o, 32'h0});
		if (rvalid_o === 1'b1 && rready_i === 1'b1)
			check({rresp_o, rdata_o});
	end

	task automatic wx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		mrac_tool_model_inst.wr(a, d);
	endtask

	task automatic rx(input logic [7:0] a, input logic [31:0] d);
		exp_q.push_back({OK, d});
		mrac_tool_model_inst.rd(a);
	endtask

	// Password and argument go first, command last
	task automatic cmd(input mrac_cmd_t c, input logic [31:0] p, input logic [31:0] g, input logic [1:0] r);
		wx(MRAC_OFS_PW, p, OK);
		wx(MRAC_OFS_ARG, g, OK);
		wx(MRAC_OFS_CMD, {28'h0, c}, r);
	endtask

	task automatic log_pulse();
		@(posedge core_clk_i);
		log_error_i <= 1'b1;
		@(posedge core_clk_i);
		log_error_i <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge core_clk_i);
		err_count++;
		complete_run();
	end

	initial
	begin
		void'($urandom(84));
		cfg = $urandom;
		pw = $urandom | 32'h1;
		mask = $urandom;
		switch_i <= 8'($urandom);
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (20) @(posedge core_clk_i);
		rx(MRAC_OFS_STATUS, 32'h01);
		wx(8'h20, 32'h0, ER);
		cmd(MRAC_CMD_DOWNLOAD, 32'h0, cfg, OK);
		rx(MRAC_OFS_STATUS, 32'h02);
		cmd(MRAC_CMD_SET_PW, 32'h0, pw, OK);
		rx(MRAC_OFS_STATUS, 32'h22);
		cmd(MRAC_CMD_TO_RUN, pw ^ 32'h1, 32'h0, ER);
		rx(MRAC_OFS_STATUS, 32'h22);
		rx(MRAC_OFS_RESULT, {24'h000000, 6'h03, MRAC_RES_ERR});
		rx(MRAC_OFS_EVENT, 32'h03);
		cmd(MRAC_CMD_TO_RUN, pw, 32'h0, OK);
		rx(MRAC_OFS_STATUS, 32'h63);
		cmd(MRAC_CMD_LOCK, pw, 32'h0, OK);
		cmd(MRAC_CMD_DOWNLOAD, pw, ~cfg, ER);
		rx(MRAC_OFS_CFG, cfg);
		for (int k = 2; k < 4; k++)
			cmd(mrac_cmd_t'(k), pw, 32'h0, ER);
		cmd(MRAC_CMD_RST_PWR, pw ^ 32'h1, 32'h0, ER);
		log_pulse();
		rx(MRAC_OFS_ERRLOG, 32'h1);
		cmd(MRAC_CMD_RST_PWR, pw, 32'h0, OK);
		repeat (20) @(posedge core_clk_i);
		rx(MRAC_OFS_STATUS, 32'h32);
		rx(MRAC_OFS_CFG, cfg);
		rx(MRAC_OFS_ERRLOG, 32'h1);
		cmd(MRAC_CMD_UNLOCK, pw, 32'h0, OK);
		cmd(MRAC_CMD_TO_RUN, pw, 32'h0, OK);
		safety_conn_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		rx(MRAC_OFS_STATUS, 32'he3);
		cmd(MRAC_CMD_RST_PWR, pw, 32'h0, ER);
		safety_conn_i <= 1'b0;
		cmd(MRAC_CMD_TO_IDLE, pw, 32'h0, OK);
		rx(MRAC_OFS_STATUS, 32'h22);
		switch_i <= ~switch_i;
		repeat (3) @(posedge core_clk_i);
		rx(MRAC_OFS_STATUS, 32'h24);
		cmd(MRAC_CMD_RST_KEEP, pw, mask, OK);
		repeat (20) @(posedge core_clk_i);
		rx(MRAC_OFS_CFG, (cfg & mask) | (MRAC_CFG_DEFAULT & ~mask));
		rx(MRAC_OFS_ERRLOG, 32'h0);
		log_pulse();
		cmd(MRAC_CMD_RST_ALL, 32'h0, 32'h0, OK);
		repeat (20) @(posedge core_clk_i);
		rx(MRAC_OFS_CFG, MRAC_CFG_DEFAULT);
		rx(MRAC_OFS_ERRLOG, 32'h0);
		critical_fault_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		rx(MRAC_OFS_STATUS, 32'h05);
		cmd(MRAC_CMD_RST_PWR, 32'h0, 32'h0, ER);
		repeat (4) @(posedge core_clk_i);
		// Mid-run reset; the diagnostic fails only after the first ten diagnostic cycles
		critical_fault_i <= 1'b0;
		rst_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (10) @(posedge core_clk_i);
		diag_fail_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		rx(MRAC_OFS_STATUS, 32'h05);
		complete_run();
	end
endmodule
